// ---- logic/pin_mux_pkg.sv ----
// Purpose: constants for the GPIO, interrupt and host/PCI pin mux
// Assumes: AHB-Lite register access, one 200 MHz clock
// Notes: shared by pin_mux_top and clock_divider
// Overview of operation
// R1: Nonmaskable interrupt fires on rising input edge, never on level.
// R2: After reset pins 7..4 are GPIO inputs, drivers off.
// R3: Set enable bit 7..4 makes the pin an edge interrupt, input only.
// R4: Each of four interrupt edges has its own polarity bit.
// R5: GPIO role is bidirectional tri-state; interrupt role is input only.
// R6: PCI mode: pins 15,14,12,9 become PCI reset, clock, grant, init select.
// R7: PCI mode: pin 13 irq A out, pin 11 request out, pin 10 bidirectional.
// R8: Pins 9..15 idle after reset until GPIO or PCI role chosen.
// R9: Pin 3 resets as input, later programmable as bidirectional GPIO.
// R10: Pin 0 defaults input; may be output GPIO or output interrupt.
// R11: Pin 8 defaults to serial port 2 clock input; may become GPIO.
// R12: Pin 2 defaults to core/6 clock out; reprogrammed, bidirectional GPIO.
// R13: Pin 1 defaults to core/4 clock out; reprogrammed, bidirectional GPIO.
// R14: PCI enable picks host port plus GPIO 15..9, or PCI.
// R15: PCI enable with serial-2 strap decides further peripheral enables.
// R16: Host mode drives host interrupt; PCI mode pin carries frame.
// R17: Host drives two select inputs choosing control, address or data.
// R18: Narrow host bus: halfword select marks first or second half.
// R19: Host drives direction select; PCI mode pin is byte enable 2.
// R20: Host mode drives host ready; PCI mode pin carries initiator ready.
// R21: Data bit 5 low at reset selects 16-bit host port.
// R22: Straps captured during reset, selection held until next reset.
`default_nettype none
package pin_mux_pkg;
  localparam int unsigned GPIO_W = 16;
  localparam int unsigned ADDR_W = 5;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FUNC = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IN = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQEN = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_POL = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h18;
  // Function register fields
  localparam int unsigned FB_GP1 = 0;
  localparam int unsigned FB_GP2 = 1;
  localparam int unsigned FB_GP8 = 2;
  localparam int unsigned FB_GP3 = 3;
  localparam int unsigned FB_GP0LO = 4;
  localparam int unsigned FB_UPPER = 6;
  localparam int unsigned FUNC_W = 7;
  // Irq enable field sits at 7..4 of its register
  localparam int unsigned IRQEN_LSB = 4;
  localparam int unsigned IRQ_N = 4;
  localparam int unsigned IRQ_PIN0 = 4;
  // Status fields
  localparam int unsigned SB_PCI = 0;
  localparam int unsigned SB_NARROW = 1;
  localparam int unsigned SB_SER2 = 2;
  localparam int unsigned SB_EEPROM = 3;
  // Reset values
  localparam logic [FUNC_W-1:0] FUNC_RST = 7'h00;
  localparam logic [GPIO_W-1:0] DIR_RST = 16'h0000;
  // Clock output ratios
  localparam int unsigned DIV_QUARTER = 4;
  localparam int unsigned DIV_SIXTH = 6;
  // Pin 0 modes
  typedef enum logic [1:0] {GP0_IN, GP0_OUT, GP0_IRQ, GP0_RSV} gp0_mode_t;
  // AHB
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : pin_mux_pkg
`default_nettype wire

// ---- logic/clock_divider.sv ----
// Purpose: square clock at core rate divided by an even ratio
// Assumes: DIV even and at least 2
// Notes: tick is the one-cycle enable on each output edge
`default_nettype none
module clock_divider #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divided output
  output logic tick,
  output logic clkDiv
);
  import pin_mux_pkg::*;
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] HALF_LAST = CW'(DIV / 2 - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lvl;
    logic tick;
  } div_state_t;

  div_state_t s, d;

  always_comb
  begin
    d = s;
    d.tick = 1'b0;
    if (s.cnt == HALF_LAST)
    begin
      d.cnt = '0;
      d.lvl = ~s.lvl;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= d;
  end

  assign tick = s.tick;
  assign clkDiv = s.lvl;
endmodule : clock_divider
`default_nettype wire

// ---- logic/pin_mux_top.sv ----
// Purpose: pin function selection for reset, interrupt, GPIO and host/PCI pins
// Assumes: AHB-Lite slave, zero wait states, whole-word accesses
// Notes: strap levels are sampled every reset cycle, last one kept
`default_nettype none
module pin_mux_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Straps
  input wire logic pciEnableStrap,
  input wire logic serial2_select_strap,
  input wire logic host_data_bit5_strap,
  // Interrupt pins and events to the core
  input wire logic nmiIn,
  output logic nmiIrq,
  output logic [pin_mux_pkg::IRQ_N-1:0] extIrq,
  // GPIO pins, enable low while driving
  input wire logic [pin_mux_pkg::GPIO_W-1:0] gpioIn,
  output logic [pin_mux_pkg::GPIO_W-1:0] gpioOut,
  output logic [pin_mux_pkg::GPIO_W-1:0] gpioOen_n,
  // Functions routed from the pins
  output logic serial2_ext_clock_in,
  output logic general_purpose_irq_out,
  output logic pci_reset_in,
  output logic pciClockIn,
  output logic pci_grant_in,
  output logic pci_init_dev_select,
  // PCI drives from the PCI core
  input wire logic pci_irq_a_out,
  input wire logic pciIrqAOen_n,
  input wire logic pci_request_out,
  input wire logic pciRequestOen_n,
  input wire logic pciCbe3Out,
  input wire logic pciCbe3Oen_n,
  output logic pci_cmd_byte_en3,
  // Host interrupt / frame pin
  input wire logic hostIrqIn,
  input wire logic pciFrameOut,
  input wire logic pciFrameOen_n,
  output logic hostIrqPinOut,
  output logic hostIrqPinOen_n,
  output logic pci_frame_line,
  // Host ready / initiator ready pin
  input wire logic hostReadyIn,
  input wire logic pciIrdyOut,
  input wire logic pciIrdyOen_n,
  output logic hostReadyPinOut,
  output logic hostReadyPinOen_n,
  output logic pci_initiator_ready_line,
  // Host control pins, forwarded in host mode
  input wire logic [3:0] hostCtlPin,
  output logic host_reg_select_hi,
  output logic host_reg_select_lo,
  output logic host_halfword_select,
  output logic host_dir_select,
  output logic pci_cmd_byte_en2,
  // Configuration seen by the rest of the chip
  output logic pciMode,
  output logic narrow_host_port_mode,
  output logic serial2Enable,
  output logic eepromEnable
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic pci;
    logic narrow;
    logic ser2;
    logic apSel;
    logic apWrite;
    logic [ADDR_W-1:0] apAddr;
    logic [31:0] rdata;
    logic [FUNC_W-1:0] func;
    logic [GPIO_W-1:0] dir;
    logic [GPIO_W-1:0] outv;
    logic [IRQ_N-1:0] irqEn;
    logic [IRQ_N-1:0] pol;
    logic [IRQ_N-1:0] irqPrev;
    logic [IRQ_N-1:0] irqPulse;
    logic nmiPrev;
    logic nmiPulse;
    logic [GPIO_W-1:0] pinOut;
    logic [GPIO_W-1:0] pinOen;
    logic [3:0] ctl;
    logic hostIrqO;
    logic hostIrqOe;
    logic hostRdyO;
    logic hostRdyOe;
  } mux_state_t;

  mux_state_t s, d;
  logic quarterTick, quarterClk, sixthTick, sixthClk;
  logic [31:0] regRead;
  gp0_mode_t gp0Mode;
  logic [IRQ_N-1:0] edgeHit;

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  clock_divider #(.DIV(DIV_QUARTER)) quarterDiv (
    .clk(clk),
    .rst_n(rst_n),
    .tick(quarterTick),
    .clkDiv(quarterClk)
  );

  clock_divider #(.DIV(DIV_SIXTH)) sixthDiv (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sixthTick),
    .clkDiv(sixthClk)
  );

  // Register read mux, shared by bus read and nothing else
  function automatic logic [31:0] readReg(input mux_state_t st, input logic [ADDR_W-1:0] a,
                                          input logic [GPIO_W-1:0] pins);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_FUNC: r[FUNC_W-1:0] = st.func;
      OFS_DIR: r[GPIO_W-1:0] = st.dir;
      OFS_OUT: r[GPIO_W-1:0] = st.outv;
      OFS_IN: r[GPIO_W-1:0] = pins;
      OFS_IRQEN: r[IRQEN_LSB +: IRQ_N] = st.irqEn;
      OFS_POL: r[IRQ_N-1:0] = st.pol;
      OFS_STAT:
      begin
        r[SB_PCI] = st.pci;
        r[SB_NARROW] = st.narrow;
        r[SB_SER2] = st.ser2;
        r[SB_EEPROM] = st.pci & ~st.ser2;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : readReg

  assign regRead = readReg(s, haddr, gpioIn);
  assign gp0Mode = gp0_mode_t'(s.func[FB_GP0LO +: 2]);
  // Edge per polarity bit: 1 rising, 0 falling
  assign edgeHit = (s.pol & gpioIn[IRQ_PIN0 +: IRQ_N] & ~s.irqPrev) |
                   (~s.pol & ~gpioIn[IRQ_PIN0 +: IRQ_N] & s.irqPrev); // R4

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = s;
    // Bus address phase
    d.apSel = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    d.apWrite = hwrite;
    d.apAddr = haddr;
    if (d.apSel && !hwrite)
      d.rdata = regRead;
    // Data phase write; hsize is not decoded, so narrow sizes write like whole words
    if (s.apSel && s.apWrite)
    begin
      unique case (s.apAddr)
        OFS_FUNC: d.func = hwdata[FUNC_W-1:0];
        OFS_DIR: d.dir = hwdata[GPIO_W-1:0];
        OFS_OUT: d.outv = hwdata[GPIO_W-1:0];
        OFS_IRQEN: d.irqEn = hwdata[IRQEN_LSB +: IRQ_N];
        OFS_POL: d.pol = hwdata[IRQ_N-1:0];
        default: d.func = s.func;
      endcase
    end
    // Edge detection
    d.nmiPrev = nmiIn;
    d.nmiPulse = nmiIn & ~s.nmiPrev; // R1
    d.irqPrev = gpioIn[IRQ_PIN0 +: IRQ_N];
    d.irqPulse = edgeHit & s.irqEn; // R3
    // Pin 0
    d.pinOut[0] = s.outv[0];
    d.pinOen[0] = (gp0Mode == GP0_IN) || (gp0Mode == GP0_RSV); // R10
    // Pins 1, 2: divided clocks until handed to GPIO
    d.pinOut[1] = s.func[FB_GP1] ? s.outv[1] : quarterClk; // R13
    d.pinOen[1] = s.func[FB_GP1] ? ~s.dir[1] : 1'b0; // R13
    d.pinOut[2] = s.func[FB_GP2] ? s.outv[2] : sixthClk; // R12
    d.pinOen[2] = s.func[FB_GP2] ? ~s.dir[2] : 1'b0; // R12
    // Pin 3
    d.pinOut[3] = s.outv[3];
    d.pinOen[3] = s.func[FB_GP3] ? ~s.dir[3] : 1'b1; // R9
    // Pins 4..7: interrupt role forces input
    for (int i = 0; i < IRQ_N; i++)
    begin
      d.pinOut[IRQ_PIN0 + i] = s.outv[IRQ_PIN0 + i];
      d.pinOen[IRQ_PIN0 + i] = s.irqEn[i] | ~s.dir[IRQ_PIN0 + i]; // R2 R5
    end
    // Pin 8
    d.pinOut[8] = s.outv[8];
    d.pinOen[8] = s.func[FB_GP8] ? ~s.dir[8] : 1'b1; // R11
    // Pins 9..15
    for (int i = 9; i < GPIO_W; i++)
    begin
      d.pinOut[i] = s.outv[i];
      d.pinOen[i] = (s.func[FB_UPPER] && !s.pci) ? ~s.dir[i] : 1'b1; // R8 R14
    end
    if (s.pci)
    begin
      d.pinOut[13] = pci_irq_a_out; // R7
      d.pinOen[13] = pciIrqAOen_n;
      d.pinOut[11] = pci_request_out;
      d.pinOen[11] = pciRequestOen_n;
      d.pinOut[10] = pciCbe3Out;
      d.pinOen[10] = pciCbe3Oen_n;
    end
    // Host pins swap with PCI signals
    d.hostIrqO = s.pci ? pciFrameOut : hostIrqIn; // R16
    d.hostIrqOe = s.pci ? pciFrameOen_n : 1'b0;
    d.hostRdyO = s.pci ? pciIrdyOut : hostReadyIn; // R20
    d.hostRdyOe = s.pci ? pciIrdyOen_n : 1'b0;
    d.ctl = s.pci ? 4'h0 : hostCtlPin; // R17 R18 R19
    // Straps caught while reset is held
    if (!rst_n)
    begin
      d = '0;
      d.pci = pciEnableStrap; // R22 R14
      d.narrow = ~host_data_bit5_strap; // R21
      d.ser2 = serial2_select_strap;
      d.func = FUNC_RST;
      d.dir = DIR_RST;
      d.pinOen = '1;
      d.pinOen[1] = 1'b0; // R13
      d.pinOen[2] = 1'b0; // R12
      // Host mode drives from reset on; PCI mode releases
      d.hostIrqOe = pciEnableStrap; // R16
      d.hostRdyOe = pciEnableStrap; // R20
      // Level held through reset must not look like an edge
      d.nmiPrev = nmiIn; // R1
      d.irqPrev = gpioIn[IRQ_PIN0 +: IRQ_N];
    end
  end

  // Straps are sampled even in reset, so no reset branch here
  always_ff @(posedge clk)
  begin
    s <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign nmiIrq = s.nmiPulse;
  assign extIrq = s.irqPulse;
  assign gpioOut = s.pinOut;
  assign gpioOen_n = s.pinOen;
  assign serial2_ext_clock_in = gpioIn[8] & ~s.func[FB_GP8]; // R11
  assign general_purpose_irq_out = s.outv[0] & (gp0Mode == GP0_IRQ);
  assign pci_reset_in = gpioIn[15] & s.pci; // R6
  assign pciClockIn = gpioIn[14] & s.pci;
  assign pci_grant_in = gpioIn[12] & s.pci;
  assign pci_init_dev_select = gpioIn[9] & s.pci;
  assign pci_cmd_byte_en3 = gpioIn[10] & s.pci;
  assign hostIrqPinOut = s.hostIrqO;
  assign hostIrqPinOen_n = s.hostIrqOe;
  assign pci_frame_line = hostCtlPin[0] & s.pci;
  assign hostReadyPinOut = s.hostRdyO;
  assign hostReadyPinOen_n = s.hostRdyOe;
  assign pci_initiator_ready_line = hostCtlPin[1] & s.pci;
  assign host_reg_select_hi = s.ctl[3];
  assign host_reg_select_lo = s.ctl[2];
  assign host_halfword_select = s.ctl[1] & s.narrow; // R18
  assign host_dir_select = s.ctl[0];
  assign pci_cmd_byte_en2 = hostCtlPin[0] & s.pci; // R19
  assign pciMode = s.pci;
  assign narrow_host_port_mode = s.narrow; // R21
  // Serial port 2 unless PCI took its pins for the EEPROM
  assign serial2Enable = ~s.pci | s.ser2; // R15
  assign eepromEnable = s.pci & ~s.ser2; // R15

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_nmi_rise: assert property ($rose(nmiIn) |=> nmiIrq ##1 !nmiIrq) // R1
    else $error("nmi rising edge not seen");
  chk_reset_inputs: assert property ($rose(rst_n) |-> gpioOen_n[7:3] == 5'h1f) // R2
    else $error("pins 7..3 drive after reset");
  chk_irq_input: assert property ((s.irqEn != 4'h0) |=> ((gpioOen_n[7:4] | ~$past(s.irqEn)) == 4'hf)) // R5
    else $error("interrupt pin drives");
  chk_edge_polar: assert property ((s.irqEn[0] && (s.pol[0] ? $rose(gpioIn[4]) : $fell(gpioIn[4]))) |=> extIrq[0]) // R4
    else $error("selected edge interrupt missed");
  chk_pci_inputs: assert property (pciMode |-> gpioOen_n[15] && gpioOen_n[14] && gpioOen_n[12] && gpioOen_n[9]) // R6
    else $error("PCI input pin drives");
  chk_pci_request: assert property (pciMode |=> gpioOen_n[11] == $past(pciRequestOen_n)) // R7
    else $error("PCI request enable not followed");
  chk_upper_idle: assert property ((!pciMode && !s.func[FB_UPPER]) |=> gpioOen_n[15:9] == 7'h7f) // R8
    else $error("idle upper pins drive");
  chk_quarter_clk: assert property (quarterTick |=> !quarterTick ##1 quarterTick) // R13
    else $error("quarter clock period wrong");
  chk_sixth_clk: assert property (sixthTick |=> !sixthTick [*2] ##1 sixthTick) // R12
    else $error("sixth clock period wrong");
  chk_strap_hold: assert property ($stable(pciMode) && $stable(narrow_host_port_mode)) // R22
    else $error("strap selection changed");
  chk_host_drive: assert property (!pciMode |-> !hostIrqPinOen_n && !hostReadyPinOen_n) // R16
    else $error("host outputs not driven");
endmodule : pin_mux_top
`default_nettype wire

// ---- sim/host_partner.sv ----
// Purpose: far-side host model for the pin mux bench
// Assumes: external levels come from the bench; device drive wins on a driven pin
// Notes: host control lines move only just after a rising edge
`default_nettype none
module host_partner (
  // Clock
  input wire logic clk,
  // Device pin drive
  input wire logic [15:0] gpioOut,
  input wire logic [15:0] gpioOen_n,
  // Far-side levels
  input wire logic [15:0] extPin,
  output logic [15:0] gpioIn,
  output logic [3:0] hostCtlPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------
  // Host access and pin wiring
  // ------------------------------
  initial hostCtlPin = 4'h0;
  // A released pin shows the far-side level, never the last driven one
  assign gpioIn = (gpioOut & ~gpioOen_n) | (extPin & gpioOen_n);
  task automatic access(input logic [1:0] sel, input logic half, input logic dir);
    @(posedge clk);
    hostCtlPin <= {sel, half, dir};
  endtask : access
endmodule : host_partner
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for pin_mux_top
// Assumes: zero-wait AHB slave, straps stable in the last reset cycle
// Notes: three boots cover host wide, host narrow and PCI mode
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_mux_pkg::*;
  logic clk = 1'b0;
  logic rst_n, hsel, hwrite, hready, hreadyout, hresp, nmiIn, nmiIrq;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic pciEnableStrap, serial2_select_strap, host_data_bit5_strap;
  logic [IRQ_N-1:0] extIrq;
  logic [GPIO_W-1:0] gpioIn, gpioOut, gpioOen_n, extPin;
  logic serial2_ext_clock_in, general_purpose_irq_out, pci_reset_in, pciClockIn, pci_grant_in;
  logic pci_init_dev_select, pci_irq_a_out, pciIrqAOen_n, pci_request_out, pciRequestOen_n;
  logic pciCbe3Out, pciCbe3Oen_n, pci_cmd_byte_en3, hostIrqIn, pciFrameOut, pciFrameOen_n;
  logic hostIrqPinOut, hostIrqPinOen_n, pci_frame_line, hostReadyIn, pciIrdyOut, pciIrdyOen_n;
  logic hostReadyPinOut, hostReadyPinOen_n, pci_initiator_ready_line;
  logic [3:0] hostCtlPin;
  logic host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_dir_select, pci_cmd_byte_en2;
  logic pciMode, narrow_host_port_mode, serial2Enable, eepromEnable;
  logic [4:0] ev;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  int cnt [5];
  assign hready = hreadyout;
  assign ev = {extIrq, nmiIrq};
  pin_mux_top DUT (.*);
  host_partner host (.clk(clk), .gpioOut(gpioOut), .gpioOen_n(gpioOen_n), .extPin(extPin),
    .gpioIn(gpioIn), .hostCtlPin(hostCtlPin));
  always #2.5 clk = ~clk;
  // ------------------------------
  // Bench plumbing
  // ------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic ahb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic pins(input logic [15:0] v);
    @(posedge clk);
    extPin <= v;
  endtask : pins
  // Counts cycles high, so a stretched pulse shows as a count above one
  task automatic watch(input int c);
    foreach (cnt[k]) cnt[k] = 0;
    repeat (c)
    begin
      @(posedge clk);
      #1;
      foreach (cnt[k]) cnt[k] += int'(ev[k] === 1'b1);
    end
  endtask : watch
  task automatic toggles(input int i, output int t);
    logic p;
    t = 0;
    tick(1);
    p = gpioOut[i];
    repeat (12)
    begin
      tick(1);
      t += int'(gpioOut[i] !== p);
      p = gpioOut[i];
    end
  endtask : toggles
  task automatic boot(input logic p, input logic s, input logic h);
    @(posedge clk);
    rst_n <= 1'b0;
    {pciEnableStrap, serial2_select_strap, host_data_bit5_strap} <= {p, s, h};
    tick(10);
    @(posedge clk);
    rst_n <= 1'b1;
    {pciEnableStrap, serial2_select_strap, host_data_bit5_strap} <= ~{p, s, h};
    tick(3);
    `CHK("config", {p, ~h, ~p | s, p & ~s}, {pciMode, narrow_host_port_mode, serial2Enable, eepromEnable})
    `CHK("oen reset", 16'hfff9, gpioOen_n)
    ahb(1'b0, OFS_STAT, 32'h0);
    `CHK("status", {28'h0, p & ~s, s, ~h, p}, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : boot
  task automatic host_chk(input logic nar);
    host.access(2'b01, 1'b1, 1'b0);
    @(posedge clk);
    hostIrqIn <= 1'b1;
    hostReadyIn <= 1'b1;
    tick(2);
    `CHK("host ctl", {2'b01, nar, 1'b0}, {host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_dir_select})
    `CHK("host pins", 4'b1010, {hostIrqPinOut, hostIrqPinOen_n, hostReadyPinOut, hostReadyPinOen_n})
    `CHK("pci idle", 3'b000, {pci_frame_line, pci_initiator_ready_line, pci_cmd_byte_en3})
  endtask : host_chk
  // ------------------------------
  // Tests
  // ------------------------------
  initial
  begin
    {rst_n, hsel, hwrite, nmiIn, hostIrqIn, hostReadyIn, pciFrameOut, pciIrdyOut} = '0;
    {pci_irq_a_out, pci_request_out, pciCbe3Out} = '0;
    {pciIrqAOen_n, pciRequestOen_n, pciCbe3Oen_n, pciFrameOen_n, pciIrdyOen_n} = '1;
    {pciEnableStrap, serial2_select_strap, host_data_bit5_strap} = 3'b011;
    haddr = '0;
    htrans = '0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    extPin = '0;
    boot(1'b0, 1'b1, 1'b1);
    pins(16'h8100);
    tick(1);
    `CHK("ser2 clk", 1'b1, serial2_ext_clock_in)
    `CHK("pci rst", 1'b0, pci_reset_in)
    ahb(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    toggles(1, n);
    `CHK("div4", 6, n)
    toggles(2, n);
    `CHK("div6", 4, n)
    $display("test defaults done");
    @(posedge clk);
    nmiIn <= 1'b1;
    watch(8);
    `CHK("nmi rise", 1, cnt[0])
    @(posedge clk);
    nmiIn <= 1'b0;
    watch(8);
    `CHK("nmi fall", 0, cnt[0])
    $display("test nmi done");
    ahb(1'b1, OFS_DIR, 32'hf0);
    ahb(1'b1, OFS_IRQEN, 32'hf0);
    ahb(1'b1, OFS_POL, 32'h5);
    tick(2);
    `CHK("irq pins in", 4'hf, gpioOen_n[7:4])
    pins(16'h00f0);
    watch(6);
    for (int k = 0; k < 4; k++) `CHK("irq rise", int'(k % 2 == 0), cnt[k + 1])
    pins(16'h0000);
    watch(6);
    for (int k = 0; k < 4; k++) `CHK("irq fall", k % 2, cnt[k + 1])
    $display("test irq done");
    ahb(1'b1, OFS_IRQEN, 32'h0);
    ahb(1'b1, OFS_FUNC, 32'h4f);
    ahb(1'b1, OFS_DIR, 32'hffff);
    ahb(1'b1, OFS_OUT, 32'ha5c3);
    tick(2);
    `CHK("gpio oen", 16'h0001, gpioOen_n)
    `CHK("gpio out", 16'ha5c2, gpioOut & 16'hfffe)
    ahb(1'b1, OFS_FUNC, 32'h5f);
    tick(2);
    `CHK("gp0 out", 2'b01, {gpioOen_n[0], gpioOut[0]})
    ahb(1'b1, OFS_FUNC, 32'h6f);
    tick(2);
    `CHK("gp0 irq", 2'b01, {gpioOen_n[0], general_purpose_irq_out})
    ahb(1'b0, OFS_FUNC, 32'h0);
    `CHK("func rd", 32'h6f, rd)
    ahb(1'b0, OFS_IN, 32'h0);
    `CHK("pins rd", 32'ha5c3, rd)
    host_chk(1'b0);
    $display("test gpio and host done");
    boot(1'b0, 1'b0, 1'b0);
    host_chk(1'b1);
    $display("test narrow host done");
    boot(1'b1, 1'b0, 1'b1);
    pins(16'hd200);
    pci_irq_a_out <= 1'b1;
    pciIrqAOen_n <= 1'b0;
    pciCbe3Out <= 1'b1;
    pciCbe3Oen_n <= 1'b0;
    {pciFrameOut, pciFrameOen_n, pciIrdyOut, pciIrdyOen_n} <= 4'b1010;
    host.access(2'b11, 1'b1, 1'b1);
    tick(2);
    `CHK("pci in", 4'hf, {pci_reset_in, pciClockIn, pci_grant_in, pci_init_dev_select})
    `CHK("pci oen", 4'b0101, {gpioOen_n[13], gpioOen_n[11], gpioOen_n[10], gpioOen_n[9]})
    `CHK("pci out", 2'b11, {gpioOut[13], gpioOut[10]})
    `CHK("cbe3 in", 1'b1, pci_cmd_byte_en3)
    `CHK("frame irdy", 4'b1010, {hostIrqPinOut, hostIrqPinOen_n, hostReadyPinOut, hostReadyPinOen_n})
    `CHK("host gated", 4'h0, {host_reg_select_hi, host_reg_select_lo, host_halfword_select, host_dir_select})
    `CHK("cbe2", 1'b1, pci_cmd_byte_en2)
    $display("test pci done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
